// ---- clfs_pkg.sv ----
package clfs_pkg;

    // Bus identity and register indices
    localparam logic [6:0] I2C_TARGET_ADDR = 7'h6A;
    localparam logic [7:0] REG_INPUT_LIMIT = 8'h07;
    localparam logic [7:0] REG_FINISH = 8'h08;
    localparam logic [7:0] REG_LOCK = 8'h0A;

    // Reset values
    localparam logic [6:0] INPUT_LIMIT_RST = 7'h14;
    localparam logic [7:0] FINISH_RST = 8'h60;
    localparam logic [1:0] LOCK_RST = 2'h0;
    localparam logic [1:0] LOCK_OPEN = 2'h3;

    // Field positions
    localparam int INLIM_CODE_LSB = 0;
    localparam int INLIM_CODE_W = 6;
    localparam int INLIM_REG_W = 7;
    localparam int FIN_DUR_LSB = 5;
    localparam int FIN_TEST_BIT = 4;
    localparam int FIN_LVL_LSB = 2;
    localparam int FIN_VTERM_LSB = 0;
    localparam int LOCK_LSB = 2;

    // Input limit decode, codes then values in mA
    localparam logic [5:0] INLIM_BASE_CODE = 6'h0A;
    localparam logic [5:0] INLIM_TOP_CODE = 6'h3C;
    localparam logic [5:0] INLIM_OFF_CODE = 6'h3F;
    localparam logic [10:0] INLIM_MIN_MA = 11'h064;
    localparam logic [10:0] INLIM_BASE_MA = 11'h0FA;
    localparam logic [10:0] INLIM_STEP_MA = 11'h019;
    localparam logic [10:0] INLIM_MAX_MA = 11'h5DC;
    // Comparator threshold is 95 percent of target
    localparam logic [15:0] THRESH_NUM = 16'h0013;
    localparam logic [15:0] THRESH_DEN = 16'h0014;

    // Finish phase decode
    localparam logic [6:0] FIN_DUR_STEP_MIN = 7'h0A;
    localparam logic [7:0] FIN_LVL_STEP_MA = 8'h32;
    localparam logic [11:0] FAST_MAX_NORMAL_MA = 12'h60E;
    localparam logic [11:0] FAST_MAX_TEST_MA = 12'hAF0;

    // Termination voltage in mV, indexed by code
    localparam logic [12:0] VTERM_STD_MV [0:3] =
        '{13'h1068, 13'h1004, 13'h10FE, 13'h1036};
    localparam logic [12:0] VTERM_HV_MV [0:3] =
        '{13'h10FE, 13'h1130, 13'h1162, 13'h1194};

endpackage : clfs_pkg

// ---- clfs_i2c_target.sv ----
`timescale 1ns/1ps
`default_nettype none
module clfs_i2c_target
    import clfs_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic scl_in, // Bus clock level
    input wire logic sda_in, // Bus data level
    output logic sda_out, // Data drive value, always low
    output logic sda_oe, // Data pulled low while high
    output logic [7:0] rd_addr, // Register index for read data
    input wire logic [7:0] rd_data, // Read data for rd_addr
    output logic wr_stb, // One-cycle write strobe
    output logic [7:0] wr_addr, // Write register index
    output logic [7:0] wr_data // Write data
);

    typedef enum logic [2:0] {
        I_IDLE, I_ADDR, I_REG, I_WDATA, I_RDATA, I_ACK, I_MACK
    } clfs_i2c_st_e;

    typedef struct packed {
        clfs_i2c_st_e st;
        clfs_i2c_st_e after;
        logic scl_q;
        logic sda_q;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic oe;
        logic stb;
        logic [7:0] waddr;
        logic [7:0] wdata;
    } clfs_i2c_s;

    clfs_i2c_s s;
    clfs_i2c_s next_s;
    logic start_c;
    logic stop_c;
    logic rise_c;
    logic fall_c;

    always_comb begin
        start_c = s.scl_q & scl_in & s.sda_q & ~sda_in;
        stop_c = s.scl_q & scl_in & ~s.sda_q & sda_in;
        rise_c = scl_in & ~s.scl_q;
        fall_c = ~scl_in & s.scl_q;
        next_s = s;
        next_s.scl_q = scl_in;
        next_s.sda_q = sda_in;
        next_s.stb = 1'b0;
        if (srst) begin
            next_s = '0;
            next_s.st = I_IDLE;
            next_s.after = I_IDLE;
            // Idle bus levels, so release never looks like an edge
            next_s.scl_q = 1'b1;
            next_s.sda_q = 1'b1;
        end else if (start_c) begin
            // Repeated start keeps the pointer for register reads
            next_s.st = I_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.oe = 1'b0;
        end else if (stop_c) begin
            next_s.st = I_IDLE;
            next_s.oe = 1'b0;
        end else begin
            case (s.st)
                I_ADDR, I_REG, I_WDATA: begin
                    if (rise_c && s.bitcnt < 4'h8) begin
                        next_s.shreg = {s.shreg[6:0], sda_in};
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (fall_c && s.bitcnt == 4'h8) begin
                        next_s.bitcnt = 4'h0;
                        next_s.oe = 1'b1;
                        next_s.st = I_ACK;
                        if (s.st == I_ADDR) begin
                            if (s.shreg[7:1] == I2C_TARGET_ADDR) begin
                                next_s.after = s.shreg[0] ? I_RDATA : I_REG;
                            end else begin
                                next_s.oe = 1'b0;
                                next_s.st = I_IDLE;
                            end
                        end else if (s.st == I_REG) begin
                            next_s.ptr = s.shreg;
                            next_s.after = I_WDATA;
                        end else begin
                            // Locked writes are still acknowledged
                            next_s.stb = 1'b1;
                            next_s.waddr = s.ptr;
                            next_s.wdata = s.shreg;
                            next_s.ptr = s.ptr + 8'h01;
                            next_s.after = I_WDATA;
                        end
                    end
                end
                I_ACK: begin
                    if (fall_c) begin
                        next_s.oe = 1'b0;
                        next_s.st = s.after;
                        if (s.after == I_RDATA) begin
                            next_s.shreg = rd_data;
                            next_s.oe = ~rd_data[7];
                            next_s.ptr = s.ptr + 8'h01;
                            next_s.bitcnt = 4'h0;
                        end
                    end
                end
                I_RDATA: begin
                    if (rise_c) begin
                        next_s.bitcnt = s.bitcnt + 4'h1;
                    end else if (fall_c) begin
                        if (s.bitcnt == 4'h8) begin
                            next_s.oe = 1'b0;
                            next_s.bitcnt = 4'h0;
                            next_s.st = I_MACK;
                        end else begin
                            next_s.shreg = {s.shreg[6:0], 1'b0};
                            next_s.oe = ~s.shreg[6];
                        end
                    end
                end
                I_MACK: begin
                    // Master ack reuses the ack state to load the next byte
                    if (rise_c) begin
                        next_s.st = sda_in ? I_IDLE : I_ACK;
                        next_s.after = I_RDATA;
                    end
                end
                default: begin
                    next_s.st = I_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    assign sda_out = 1'b0;
    assign sda_oe = s.oe;
    assign rd_addr = s.ptr;
    assign wr_stb = s.stb;
    assign wr_addr = s.waddr;
    assign wr_data = s.wdata;

endmodule : clfs_i2c_target
`default_nettype wire

// ---- clfs_top.sv ----
// Functional notes
// - Input limit codes 0 through 9 all give a 100 mA target.
// - Codes from 10 give 250 mA plus 25 mA per step up to 1500 mA at code 60, and code 63 turns the limit off.
// - The finish-phase register sits at index 0x08 of bus target 0x6A and is readable and writable.
// - The settings go back to defaults while the standby supply is invalid and on each rise of safe-out power good.
// - Bits 7 to 5 set the finish-phase time in 10 minute steps, default code 3.
// - Bit 4, default 0, raises the fast-charge ceiling to 2.8 A for pulsed testing only.
// - The finish timer starts when sensed current reaches the level of bits 3 to 2, 50 mA per step from 50 mA.
// - Protected settings take writes only while the lock key holds 11.
// - The decoded input limit is enforced only while the converter runs, default 500 mA.
`timescale 1ns/1ps
`default_nettype none
module clfs_top
    import clfs_pkg::*;
(
    input wire logic clk, // System clock, 125 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic scl_in, // Bus clock level
    input wire logic sda_in, // Bus data level
    output logic sda_out, // Data drive value
    output logic sda_oe, // Data drive enable
    input wire logic standby_supply_valid, // Standby supply good
    input wire logic safeout_power_good, // Safe-out rail good
    input wire logic dcdc_running, // Converter operating
    input wire logic high_voltage_variant, // Part selects high-voltage set
    input wire logic [10:0] sensed_charge_current, // Charge current, mA
    output logic [10:0] input_limit_ma, // Decoded target limit, mA
    output logic [10:0] input_limit_threshold, // Comparator level, mA
    output logic input_limit_off, // Limit disabled by code
    output logic input_limit_enforce, // Limit applied to input now
    output logic [6:0] finish_phase_duration, // Finish time, minutes
    output logic pulsed_high_current_test, // Test scaling enabled
    output logic [11:0] fast_charge_ceiling_ma, // Fast-charge ceiling, mA
    output logic [7:0] finish_current_level, // Finish threshold, mA
    output logic [12:0] termination_voltage_mv, // Termination voltage, mV
    output logic finish_level_reached, // Current at or below level
    output logic finish_timer_start // One-cycle timer start
);

    typedef struct packed {
        logic [6:0] inlim;
        logic [7:0] finish;
        logic [1:0] lock;
        logic pg_q;
        logic [10:0] lim_ma;
        logic [10:0] lim_thr;
        logic lim_off;
        logic lim_enf;
        logic [6:0] dur_min;
        logic test;
        logic [11:0] fast_max;
        logic [7:0] fin_ma;
        logic [12:0] vterm;
        logic reached;
        logic fin_start;
    } clfs_top_s;

    clfs_top_s s;
    clfs_top_s next_s;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic restore_c;
    logic standby_lost_c;
    logic safeout_rise_c;
    logic [5:0] code_c;

    function automatic logic [10:0] clfs_limit_ma(input logic [5:0] c);
        logic [10:0] steps;
        steps = 11'(c - INLIM_BASE_CODE);
        if (c < INLIM_BASE_CODE) begin
            clfs_limit_ma = INLIM_MIN_MA;
        end else if (c <= INLIM_TOP_CODE) begin
            clfs_limit_ma = 11'(INLIM_BASE_MA + INLIM_STEP_MA * steps);
        end else begin
            // Reserved codes clamp; the off code also reports the top value
            clfs_limit_ma = INLIM_MAX_MA;
        end
    endfunction : clfs_limit_ma

    // Rounds down; the product of the top limit still fits in 16 bits
    function automatic logic [10:0] clfs_threshold_ma(input logic [10:0] t);
        logic [15:0] p;
        p = 16'(16'(t) * THRESH_NUM) / THRESH_DEN;
        clfs_threshold_ma = p[10:0];
    endfunction : clfs_threshold_ma

    // Code 0 gives a finish phase of zero length
    function automatic logic [6:0] clfs_finish_min(input logic [2:0] c);
        clfs_finish_min = 7'(FIN_DUR_STEP_MIN * 7'(c));
    endfunction : clfs_finish_min

    // Levels start one step up, so code 0 is never zero current
    function automatic logic [7:0] clfs_finish_ma(input logic [1:0] c);
        clfs_finish_ma = 8'(FIN_LVL_STEP_MA * (8'(c) + 8'h01));
    endfunction : clfs_finish_ma

    // Variant pin is read live, so no rewrite is needed after a strap change
    function automatic logic [12:0] clfs_vterm_mv(input logic [1:0] c,
        input logic hv);
        if (hv) begin
            clfs_vterm_mv = VTERM_HV_MV[c];
        end else begin
            clfs_vterm_mv = VTERM_STD_MV[c];
        end
    endfunction : clfs_vterm_mv

    // Any key but the open pattern keeps the protected fields locked
    function automatic logic clfs_unlocked(input logic [1:0] key);
        clfs_unlocked = (key == LOCK_OPEN);
    endfunction : clfs_unlocked

    // Unmapped indices and spare bits read back as zero
    function automatic logic [7:0] clfs_read_reg(input logic [7:0] idx,
        input logic [6:0] inlim, input logic [7:0] fin, input logic [1:0] key);
        case (idx)
            REG_INPUT_LIMIT: clfs_read_reg = {1'b0, inlim};
            REG_FINISH: clfs_read_reg = fin;
            REG_LOCK: clfs_read_reg = {4'h0, key, 2'h0};
            default: clfs_read_reg = 8'h00;
        endcase
    endfunction : clfs_read_reg

    clfs_i2c_target u_i2c (
        .clk(clk),
        .srst(srst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    always_comb begin
        rd_data = clfs_read_reg(rd_addr, s.inlim, s.finish, s.lock);
    end

    always_comb begin
        next_s = s;
        next_s.pg_q = safeout_power_good;
        // Either source alone returns every register, the key too, to default
        standby_lost_c = ~standby_supply_valid;
        safeout_rise_c = safeout_power_good & ~s.pg_q;
        restore_c = srst | standby_lost_c | safeout_rise_c;
        if (restore_c) begin
            next_s.inlim = INPUT_LIMIT_RST;
            next_s.finish = FINISH_RST;
            next_s.lock = LOCK_RST;
        end else if (wr_stb) begin
            case (wr_addr)
                REG_INPUT_LIMIT: begin
                    if (clfs_unlocked(s.lock)) begin
                        next_s.inlim = wr_data[INLIM_REG_W-1:0];
                    end
                end
                REG_FINISH: begin
                    if (clfs_unlocked(s.lock)) begin
                        next_s.finish = wr_data;
                    end
                end
                REG_LOCK: begin
                    // Lock key itself is never protected, or it could not open
                    next_s.lock = wr_data[LOCK_LSB +: 2];
                end
                default: begin
                end
            endcase
        end
        // Cleared in reset, so a good rail at release restores once more
        if (srst) begin
            next_s.pg_q = 1'b0;
        end

        // Outputs follow the new settings one cycle after a write
        code_c = next_s.inlim[INLIM_CODE_LSB +: INLIM_CODE_W];
        next_s.lim_ma = clfs_limit_ma(code_c);
        next_s.lim_thr = clfs_threshold_ma(next_s.lim_ma);
        next_s.lim_off = (code_c == INLIM_OFF_CODE);
        // Follows the converter live; it is not a stored setting
        next_s.lim_enf = dcdc_running & ~next_s.lim_off;
        next_s.dur_min = clfs_finish_min(next_s.finish[FIN_DUR_LSB +: 3]);
        // Scaling follows the bit; keeping it pulsed is up to the host
        next_s.test = next_s.finish[FIN_TEST_BIT];
        next_s.fast_max = next_s.test ? FAST_MAX_TEST_MA
                                      : FAST_MAX_NORMAL_MA;
        next_s.fin_ma = clfs_finish_ma(next_s.finish[FIN_LVL_LSB +: 2]);
        next_s.vterm = clfs_vterm_mv(next_s.finish[FIN_VTERM_LSB +: 2],
            high_voltage_variant);
        // Current falls toward the level as the cell fills
        next_s.reached = ~srst &
            (sensed_charge_current <= 11'(next_s.fin_ma));
        next_s.fin_start = next_s.reached & ~s.reached;
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    assign input_limit_ma = s.lim_ma;
    assign input_limit_threshold = s.lim_thr;
    assign input_limit_off = s.lim_off;
    assign input_limit_enforce = s.lim_enf;
    assign finish_phase_duration = s.dur_min;
    assign pulsed_high_current_test = s.test;
    assign fast_charge_ceiling_ma = s.fast_max;
    assign finish_current_level = s.fin_ma;
    assign termination_voltage_mv = s.vterm;
    assign finish_level_reached = s.reached;
    assign finish_timer_start = s.fin_start;

endmodule : clfs_top
`default_nettype wire

// ---- clfs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module clfs_monitor
    import clfs_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic srst, // Reset
    input wire logic standby_supply_valid, // Standby good
    input wire logic safeout_power_good, // Safe-out good
    input wire logic dcdc_running, // Converter on
    input wire logic high_voltage_variant, // Variant
    input wire logic [10:0] sensed_charge_current, // Current
    input wire logic [10:0] input_limit_ma, // Limit
    input wire logic [10:0] input_limit_threshold, // Threshold
    input wire logic input_limit_off, // Limit off
    input wire logic input_limit_enforce, // Enforced
    input wire logic [6:0] finish_phase_duration, // Minutes
    input wire logic pulsed_high_current_test, // Test bit
    input wire logic [11:0] fast_charge_ceiling_ma, // Ceiling
    input wire logic [7:0] finish_current_level, // Level
    input wire logic [12:0] termination_voltage_mv, // Voltage
    input wire logic finish_level_reached, // Reached
    input wire logic finish_timer_start // Start pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire dflt = finish_phase_duration == 7'h1E && finish_current_level == 8'h32
        && !pulsed_high_current_test && input_limit_ma == 11'h1F4;
    limit_thresh_a: assert property (
        32'(input_limit_threshold) == 32'(input_limit_ma) * 19 / 20)
        else $error("threshold not 95 percent of target");
    limit_range_a: assert property (
        input_limit_ma == 11'h064 || (input_limit_ma >= 11'h0FA
        && input_limit_ma <= 11'h5DC && input_limit_ma % 25 == 0))
        else $error("limit outside decode table");
    limit_off_a: assert property (
        input_limit_off |-> !input_limit_enforce)
        else $error("disabled limit still enforced");
    enforce_idle_a: assert property (
        !$past(dcdc_running) |-> !input_limit_enforce)
        else $error("limit enforced with converter off");
    finish_time_a: assert property (
        finish_phase_duration % 10 == 0 && finish_phase_duration <= 7'h46)
        else $error("finish time off the 10 minute grid");
    test_ceiling_a: assert property (
        fast_charge_ceiling_ma == (pulsed_high_current_test ? 12'hAF0 : 12'h60E))
        else $error("ceiling does not follow test bit");
    finish_level_a: assert property (
        finish_current_level inside {8'h32, 8'h64, 8'h96, 8'hC8})
        else $error("finish level not a listed step");
    vterm_hv_a: assert property (
        $past(high_voltage_variant) |-> termination_voltage_mv inside
        {13'h10FE, 13'h1130, 13'h1162, 13'h1194})
        else $error("high-voltage part outside its set");
    start_rise_a: assert property (
        $rose(finish_level_reached) |-> finish_timer_start)
        else $error("no timer start after level reached");
    start_once_a: assert property (
        finish_timer_start |-> !$past(finish_level_reached))
        else $error("timer start repeated");
    reach_above_a: assert property (
        $past(sensed_charge_current) > 11'h0C8 |-> !finish_level_reached)
        else $error("level reached above 200 mA");
    standby_rst_a: assert property (
        !standby_supply_valid [*2] |=> dflt)
        else $error("standby loss kept settings");
    safeout_rst_a: assert property (
        $rose(safeout_power_good) |-> ##2 dflt)
        else $error("safe-out rise kept settings");
    cover property (input_limit_off);
    cover property (finish_timer_start);
    cover property ($rose(safeout_power_good));
    cover property (pulsed_high_current_test);
endmodule : clfs_monitor
bind clfs_top clfs_monitor mon (.*);
`default_nettype wire

// ---- clfs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module clfs_host_model
    import clfs_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sda_wire, // Resolved data line
    output logic scl, // Bus clock, high when idle
    output logic sda // Data, high releases the line
);
    logic ack_ok = 1'b1;
    // Three clocks per level: the target samples without a filter
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic start();
        sda = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda = 1'b0;
        tick(3);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        sda = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sda = 1'b1;
        tick(3);
    endtask : stop
    task automatic xfer_bit(input logic b, output logic r);
        sda = b;
        tick(3);
        scl = 1'b1;
        tick(3);
        r = sda_wire;
        scl = 1'b0;
    endtask : xfer_bit
    task automatic put_byte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        if (r !== 1'b0) ack_ok = 1'b0;
    endtask : put_byte
    task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
        start();
        put_byte({I2C_TARGET_ADDR, 1'b0});
        put_byte(idx);
        put_byte(d);
        stop();
    endtask : reg_write
    task automatic reg_read(input logic [7:0] idx, output logic [7:0] d);
        logic r;
        start();
        put_byte({I2C_TARGET_ADDR, 1'b0});
        put_byte(idx);
        start();
        put_byte({I2C_TARGET_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
        xfer_bit(1'b1, r);
        stop();
    endtask : reg_read
endmodule : clfs_host_model
`default_nettype wire

// ---- clfs_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module clfs_top_bench;
    logic clk, srst, scl, sda_m, sda_oe, sda_wire, svalid, spg, dcdc, hv;
    logic off, enf, test, reached, tstart, sda_val;
    logic [10:0] sensed, lim, thr;
    logic [6:0] dur;
    logic [11:0] ceil_ma;
    logic [7:0] lvl, rd;
    logic [12:0] vterm;
    int miscompares = 0;
    int cmp_count = 0;
    logic [15:0] std_mv [4] = '{16'h1068, 16'h1004, 16'h10FE, 16'h1036};
    logic [15:0] hv_mv [4] = '{16'h10FE, 16'h1130, 16'h1162, 16'h1194};
    logic [5:0] codes [9] = '{6'h00, 6'h09, 6'h0A, 6'h0B, 6'h14, 6'h3C,
        6'h3D, 6'h3E, 6'h3F};
    logic [15:0] lims [9] = '{16'h0064, 16'h0064, 16'h00FA, 16'h0113,
        16'h01F4, 16'h05DC, 16'h05DC, 16'h05DC, 16'h05DC};
    // Pull-up on the data line; the host or the target can pull it low
    assign sda_wire = sda_m & ~sda_oe;
    clfs_top uut (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_val), .sda_oe(sda_oe), .standby_supply_valid(svalid),
        .safeout_power_good(spg), .dcdc_running(dcdc),
        .high_voltage_variant(hv), .sensed_charge_current(sensed),
        .input_limit_ma(lim), .input_limit_threshold(thr),
        .input_limit_off(off), .input_limit_enforce(enf),
        .finish_phase_duration(dur), .pulsed_high_current_test(test),
        .fast_charge_ceiling_ma(ceil_ma), .finish_current_level(lvl),
        .termination_voltage_mv(vterm), .finish_level_reached(reached),
        .finish_timer_start(tstart));
    clfs_host_model host (.clk(clk), .sda_wire(sda_wire), .scl(scl),
        .sda(sda_m));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic t_defaults();
        host.reg_read(8'h08, rd);
        check("finish reg", rd, 16'h0060);
        check("sda value", sda_val, 16'h0000);
        check("limit", lim, 16'h01F4);
        check("threshold", thr, 16'h01DB);
        check("enforce", enf, 16'h0001);
        check("duration", dur, 16'h001E);
        check("test bit", test, 16'h0000);
        check("ceiling", ceil_ma, 16'h060E);
        check("level", lvl, 16'h0032);
        check("vterm", vterm, 16'h1068);
    endtask : t_defaults
    task automatic t_lock();
        host.reg_write(8'h08, 8'hA5);
        host.reg_read(8'h08, rd);
        check("locked write", rd, 16'h0060);
        host.reg_write(8'h0A, 8'h0C);
        host.reg_write(8'h08, 8'hB5);
        check("duration", dur, 16'h0032);
        check("test bit", test, 16'h0001);
        check("ceiling", ceil_ma, 16'h0AF0);
        check("level", lvl, 16'h0064);
        check("vterm", vterm, 16'h1004);
        host.reg_read(8'h08, rd);
        check("unlocked write", rd, 16'h00B5);
        host.reg_write(8'h0A, 8'h08);
        host.reg_write(8'h08, 8'h00);
        host.reg_read(8'h08, rd);
        check("relocked", rd, 16'h00B5);
        check("acks", host.ack_ok, 16'h0001);
    endtask : t_lock
    task automatic t_fields();
        logic [1:0] k;
        host.reg_write(8'h0A, 8'h0C);
        for (int c = 0; c < 4; c++) begin
            k = 2'(c);
            hv = 1'b0;
            host.reg_write(8'h08, {3'(7 - c), 1'b0, k, k});
            check("duration", dur, 16'(10 * (7 - c)));
            check("level", lvl, 16'(50 * (c + 1)));
            check("ceiling", ceil_ma, 16'h060E);
            check("vterm std", vterm, std_mv[c]);
            hv = 1'b1;
            repeat (2) @(negedge clk);
            check("vterm hv", vterm, hv_mv[c]);
        end
        hv = 1'b0;
    endtask : t_fields
    task automatic t_limit();
        for (int i = 0; i < 9; i++) begin
            host.reg_write(8'h07, {2'b00, codes[i]});
            check("limit", lim, lims[i]);
            check("threshold", thr, lims[i] * 19 / 20);
            check("off", off, 16'(i == 8));
            check("enforce", enf, 16'(i != 8));
        end
        host.reg_write(8'h07, 8'h14);
        dcdc = 1'b0;
        repeat (2) @(negedge clk);
        check("enforce idle", enf, 16'h0000);
        dcdc = 1'b1;
    endtask : t_limit
    task automatic t_finish();
        int n;
        host.reg_write(8'h08, 8'h64);
        sensed = 11'h065;
        repeat (3) @(negedge clk);
        check("reached above", reached, 16'h0000);
        sensed = 11'h064;
        n = 0;
        repeat (6) begin
            @(negedge clk);
            n += int'(tstart === 1'b1);
        end
        check("reached", reached, 16'h0001);
        check("start pulses", 16'(n), 16'h0001);
        sensed = 11'h1F4;
    endtask : t_finish
    task automatic t_restore();
        host.reg_write(8'h08, 8'h0F);
        check("duration zero", dur, 16'h0000);
        svalid = 1'b0;
        repeat (2) @(negedge clk);
        svalid = 1'b1;
        host.reg_read(8'h08, rd);
        check("standby restore", rd, 16'h0060);
        host.reg_write(8'h0A, 8'h0C);
        host.reg_write(8'h08, 8'h0F);
        spg = 1'b0;
        @(negedge clk);
        spg = 1'b1;
        host.reg_read(8'h08, rd);
        check("safe-out restore", rd, 16'h0060);
        host.reg_write(8'h08, 8'h0F);
        host.reg_read(8'h08, rd);
        check("lock restored", rd, 16'h0060);
    endtask : t_restore
    initial begin
        #400000;
        miscompares++;
        test_done();
    end
    initial begin
        srst = 1'b1;
        svalid = 1'b1;
        spg = 1'b1;
        dcdc = 1'b1;
        hv = 1'b0;
        sensed = 11'h1F4;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        t_defaults();
        t_lock();
        t_fields();
        t_limit();
        t_finish();
        t_restore();
        test_done();
    end
endmodule : clfs_top_bench
`default_nettype wire
